/* File: common/uvm_pkg_defs.sv */
// Package of constants and types for the measurement power sequencer
package uvs_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_CONFIG  = 8'h04;
    localparam logic [7:0] OFF_TIMING  = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0c;
    localparam logic [7:0] OFF_WINCNT  = 8'h10;
    localparam logic [7:0] OFF_RESULT1 = 8'h14;
    localparam logic [7:0] OFF_RESULT2 = 8'h18;
    localparam logic [7:0] OFF_RESULT3 = 8'h1c;
    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PD_BIT   = 6;
    localparam int CTRL_RUN_BIT  = 7;
    localparam logic [2:0] DOS_CONFIG  = 3'h2;
    localparam logic [2:0] DOS_MEASURE = 3'h3;
    localparam logic [7:0] CTRL_RESET  = 8'h42;
    // Config register fields
    localparam int CFG_SB_BIT    = 0;
    localparam int CFG_EN_TM_BIT = 1;
    localparam int CFG_MODE_LSB  = 4;
    localparam int CFG_EDGES_LSB = 8;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    // Timing register fields
    localparam int TIM_BREAK_LSB = 0;
    localparam int TIM_CONV_LSB  = 8;
    localparam logic [11:0] TIM_RESET = 12'h619;
    // Times and cycle counts at 250 MHz
    localparam int CLK_MHZ        = 250;
    localparam int WAKE_DELAY_NS  = 4000;
    localparam int WAKE_CYC       = (WAKE_DELAY_NS * CLK_MHZ) / 1000;
    localparam int PWRUP_DELAY_US = 1200;
    localparam int PWRUP_CYC      = PWRUP_DELAY_US * CLK_MHZ;
    localparam int MIN_FULL_CONV_MS = 64;
    localparam int CONV_BASE_CYC  = 1024;
    localparam int BREAK_STEP_CYC = 8;
    localparam int RES_W = 24;
    // Measurement modes
    typedef enum logic [1:0] { MODE_REPEAT, MODE_ONESHOT, MODE_TRIG, MODE_WINDOW } uvs_mode_t;
    // Result set carried together
    typedef struct packed {
        logic [RES_W-1:0] ch1;
        logic [RES_W-1:0] ch2;
        logic [RES_W-1:0] ch3;
        logic [RES_W-1:0] win;
    } uvs_results_t;
endpackage

/* File: src/uvs_chan_counter.sv */
// Per-channel pulse density accumulators
`timescale 1ns/1ns
module uvs_chan_counter #(
    parameter int N_CH = 3,
    parameter int W    = 24
) (
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    input  wire logic               clk_en,
    input  wire logic               clear,
    input  wire logic               count_en,
    input  wire logic [N_CH-1:0]    pdm_in,
    output logic [N_CH*W-1:0]       count
);
    // =========================================
    // Accumulators
    genvar g;
    generate
        for (g = 0; g < N_CH; g++)
        begin : g_ch
            logic [W-1:0] cnt_ff;
            // Clear at start, count PDM ones during integration, saturate
            always_ff @(posedge clk_sys or negedge reset_n)
            begin
                if (!reset_n)
                    cnt_ff <= '0;
                else if (clk_en)
                begin
                    if (clear)
                        cnt_ff <= '0;
                    else if (count_en && pdm_in[g] && (cnt_ff != {W{1'b1}}))
                        cnt_ff <= cnt_ff + 1'b1;
                end
            end
            assign count[g*W +: W] = cnt_ff;
        end
    endgenerate
endmodule

/* File: src/uvs_sequencer.sv */
// Measurement sequencer with energy saving control and AHB-Lite registers
// Contract
// - With standby enabled, stand by during pause; wake within 4 us before conversion.
// - After one-shot, return to power-down, standby, or idle per enable bits.
// - One-shot end clears the run bit itself; C3h reads back 43h.
// - One-shot start with power-down and standby runs power-up then wake delay.
// - Trigger mode with power-down: falling edge starts after power-up; ready marks conversion.
// - Trigger mode ignores edges during power-up, integration or pause.
// - Window mode ignores trigger pulses in configuration state and during pause.
// - Ready output shows true integration time regardless of stop edge count.
// - Trigger mode with both savers stays standby in pause, wakes just before conversion.
// - Each channel accumulates PDM output in a counter up to 24 bits.
// - Full 16-bit result needs integration time of at least 64 ms.
// - Repeat, one-shot, trigger modes time integration with fixed internal clock cycles.
// - Window mode integrates from start edge until selected stop edge.
// - With window count enabled, count clocks across window, readable.
// - Three channel results presented in three separate output registers.
// - Stop edge count selects the ending edge; earlier edges continue measurement.
// - Any start under power-down is delayed by power-up delay, about 1.2 ms.
// - Clearing run bit or entering configuration aborts without storing results.
`timescale 1ns/1ns
module uvs_sequencer #(
    parameter int PWRUP_CYCLES = uvs_pkg::PWRUP_CYC,
    parameter int N_CH         = 3
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              hsel,
    input  wire logic [7:0]        haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              trigger_input,
    input  wire logic [N_CH-1:0]   pdm_in,
    output logic                   ready_ff,
    output logic                   power_down_ff,
    output logic                   standby_ff
);
    typedef enum logic [2:0] { ST_IDLE, ST_WAIT_TRIG, ST_PWRUP, ST_WAKE, ST_CONV,
                               ST_PAUSE } uvs_state_t;

    localparam int PAUSE_W = 24;

    uvs_state_t       state_ff;
    logic [7:0]       ctrl_ff;
    logic [15:0]      cfg_ff;
    logic [11:0]      timing_ff;
    logic [PAUSE_W-1:0] tmr_ff;
    logic [7:0]       edge_cnt_ff;
    logic             trig_d_ff;
    logic             hit_ff;
    logic             end_ff;
    logic             hwr_ff;
    logic [7:0]       hadr_ff;
    uvs_pkg::uvs_results_t res_ff;
    logic [N_CH*uvs_pkg::RES_W-1:0] cnt;
    logic [uvs_pkg::RES_W-1:0] win_ff;

    // =========================================
    // Decoded controls
    logic       run_bit, pd_bit, sb_bit, en_tm, measuring, trig_fall, cnt_clear, regular_end;
    logic [2:0] dos;
    logic [3:0] conv_sel;
    logic [7:0] break_val, edges;
    uvs_pkg::uvs_mode_t mode;
    logic [PAUSE_W-1:0] conv_cyc, pause_cyc;
    uvs_state_t nxt_state;
    logic       start_req;
    assign run_bit   = ctrl_ff[uvs_pkg::CTRL_RUN_BIT];
    assign pd_bit    = ctrl_ff[uvs_pkg::CTRL_PD_BIT];
    assign dos       = ctrl_ff[uvs_pkg::CTRL_MODE_LSB +: 3];
    assign sb_bit    = cfg_ff[uvs_pkg::CFG_SB_BIT];
    assign en_tm     = cfg_ff[uvs_pkg::CFG_EN_TM_BIT];
    assign mode      = uvs_pkg::uvs_mode_t'(cfg_ff[uvs_pkg::CFG_MODE_LSB +: 2]);
    assign edges     = cfg_ff[uvs_pkg::CFG_EDGES_LSB +: 8];
    assign break_val = timing_ff[uvs_pkg::TIM_BREAK_LSB +: 8];
    assign conv_sel  = timing_ff[uvs_pkg::TIM_CONV_LSB +: 4];
    assign measuring = (dos == uvs_pkg::DOS_MEASURE) && run_bit;
    assign trig_fall = trig_d_ff && !trigger_input;
    // Integration is a fixed count of internal clocks, 1024 doubled per step, 65536 at step 6
    assign conv_cyc  = PAUSE_W'(uvs_pkg::CONV_BASE_CYC) << conv_sel;
    assign pause_cyc = PAUSE_W'(break_val) * PAUSE_W'(uvs_pkg::BREAK_STEP_CYC);
    assign cnt_clear = (state_ff != ST_CONV) && (nxt_state == ST_CONV);
    assign regular_end = (state_ff == ST_CONV) && (nxt_state != ST_CONV) && measuring;

    // =========================================
    // Sequencer next state
    always_comb
    begin
        nxt_state = state_ff;
        start_req = 1'b0;
        if (!measuring)
            nxt_state = ST_IDLE;
        else
        begin
            case (state_ff)
                ST_IDLE, ST_WAIT_TRIG:
                begin
                    // Only edges outside power-up, integration and pause start
                    if (mode == uvs_pkg::MODE_TRIG || mode == uvs_pkg::MODE_WINDOW)
                        start_req = trig_fall;
                    else if (state_ff == ST_IDLE)
                        start_req = 1'b1;
                    if (start_req)
                    begin
                        if (pd_bit)
                            nxt_state = ST_PWRUP;
                        else if (sb_bit)
                            nxt_state = ST_WAKE;
                        else
                            nxt_state = ST_CONV;
                    end
                    else
                        nxt_state = ST_WAIT_TRIG;
                end
                ST_PWRUP:
                    if (tmr_ff == '0)
                        nxt_state = sb_bit ? ST_WAKE : ST_CONV;
                ST_WAKE:
                    if (tmr_ff == '0)
                        nxt_state = ST_CONV;
                ST_CONV:
                begin
                    if (mode == uvs_pkg::MODE_WINDOW)
                    begin
                        // Stop on the selected edge, earlier edges continue
                        if (trig_fall && (edge_cnt_ff + 8'h01 >= edges))
                            nxt_state = ST_PAUSE;
                    end
                    else if (tmr_ff == '0)
                        nxt_state = (mode == uvs_pkg::MODE_ONESHOT) ? ST_IDLE : ST_PAUSE;
                end
                ST_PAUSE: // Edges ignored while pausing
                    if (tmr_ff == '0)
                        nxt_state = (mode == uvs_pkg::MODE_REPEAT) ? ST_IDLE : ST_WAIT_TRIG;
                default:
                    nxt_state = ST_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            state_ff <= ST_IDLE;
        else if (clk_en)
            state_ff <= nxt_state;
    end

    // Phase timer loaded on entering each timed phase
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            tmr_ff <= '0;
        else if (clk_en)
        begin
            if (nxt_state != state_ff)
            begin
                case (nxt_state)
                    ST_PWRUP: tmr_ff <= PAUSE_W'(PWRUP_CYCLES - 1);
                    ST_WAKE:  tmr_ff <= PAUSE_W'(uvs_pkg::WAKE_CYC - 1);
                    ST_CONV:  tmr_ff <= conv_cyc - 1'b1;
                    ST_PAUSE: tmr_ff <= (pause_cyc == '0) ? '0 : pause_cyc - 1'b1;
                    default:  tmr_ff <= '0;
                endcase
            end
            else if (tmr_ff != '0)
                tmr_ff <= tmr_ff - 1'b1;
        end
    end

    // Trigger edge detect and window edge counter
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trig_d_ff   <= 1'b1;
            edge_cnt_ff <= '0;
        end
        else if (clk_en)
        begin
            trig_d_ff <= trigger_input;
            if (cnt_clear)
                edge_cnt_ff <= '0;
            else if (state_ff == ST_CONV && trig_fall)
                edge_cnt_ff <= edge_cnt_ff + 8'h01;
        end
    end

    // =========================================
    // Energy saving and ready outputs
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ready_ff      <= 1'b0;
            power_down_ff <= 1'b1;
            standby_ff    <= 1'b0;
        end
        else if (clk_en)
        begin
            // Ready marks the real integration interval only
            ready_ff      <= (nxt_state == ST_CONV);
            // Power-down held until power-up phase begins
            power_down_ff <= pd_bit &&
                             (nxt_state inside {ST_IDLE, ST_WAIT_TRIG, ST_PAUSE});
            // Standby in pause, during power-up and while waiting for a start
            standby_ff    <= sb_bit && (nxt_state inside {ST_IDLE, ST_WAIT_TRIG,
                             ST_PAUSE, ST_PWRUP});
        end
    end

    // =========================================
    // Channel counters and window clock count
    uvs_chan_counter #(.N_CH(N_CH), .W(uvs_pkg::RES_W)) u_cnt (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .clear    (cnt_clear),
        .count_en (state_ff == ST_CONV),
        .pdm_in   (pdm_in),
        .count    (cnt)
    );

    // Count internal clocks across the window
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            win_ff <= '0;
        else if (clk_en)
        begin
            if (cnt_clear)
                win_ff <= '0;
            else if (state_ff == ST_CONV && en_tm && win_ff != '1)
                win_ff <= win_ff + 1'b1;
        end
    end

    // Regular end delayed one cycle so the last counted clock is included
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            end_ff <= 1'b0;
        else if (clk_en)
            end_ff <= regular_end;
    end

    // Results latched only after a regular end
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            res_ff <= '0;
        else if (clk_en && end_ff)
        begin
            res_ff.ch1 <= cnt[0 +: uvs_pkg::RES_W];
            res_ff.ch2 <= cnt[uvs_pkg::RES_W +: uvs_pkg::RES_W];
            res_ff.ch3 <= cnt[2*uvs_pkg::RES_W +: uvs_pkg::RES_W];
            res_ff.win <= en_tm ? win_ff : '0;
        end
    end

    // =========================================
    // AHB-Lite slave, zero wait states
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hit_ff  <= 1'b0;
            hwr_ff  <= 1'b0;
            hadr_ff <= '0;
        end
        else if (clk_en && hready)
        begin
            hit_ff  <= hsel && htrans[1];
            hwr_ff  <= hwrite;
            hadr_ff <= haddr;
        end
    end

    // Control register; one-shot end clears run bit, hardware wins
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            ctrl_ff <= uvs_pkg::CTRL_RESET;
        else if (clk_en)
        begin
            if (hit_ff && hwr_ff && hadr_ff == uvs_pkg::OFF_CTRL)
                ctrl_ff <= hwdata[7:0];
            if (regular_end && mode == uvs_pkg::MODE_ONESHOT)
                ctrl_ff[uvs_pkg::CTRL_RUN_BIT] <= 1'b0;
        end
    end

    // Config writable only in configuration state
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_ff    <= uvs_pkg::CFG_RESET;
            timing_ff <= uvs_pkg::TIM_RESET;
        end
        else if (clk_en && hit_ff && hwr_ff && dos == uvs_pkg::DOS_CONFIG)
        begin
            if (hadr_ff == uvs_pkg::OFF_CONFIG)
                cfg_ff <= hwdata[15:0];
            else if (hadr_ff == uvs_pkg::OFF_TIMING)
                timing_ff <= hwdata[11:0];
        end
    end

    // Read mux registered from address phase
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            hrdata <= '0;
        else if (clk_en && hready)
        begin
            if (haddr == uvs_pkg::OFF_CTRL)
                hrdata <= {24'h000000, ctrl_ff};
            else if (haddr == uvs_pkg::OFF_CONFIG)
                hrdata <= {16'h0000, cfg_ff};
            else if (haddr == uvs_pkg::OFF_TIMING)
                hrdata <= {20'h00000, timing_ff};
            else if (haddr == uvs_pkg::OFF_STATUS)
                hrdata <= {24'h000000, 2'h0, standby_ff, power_down_ff, ready_ff,
                           3'(state_ff)};
            else if (haddr == uvs_pkg::OFF_WINCNT)
                hrdata <= {8'h00, res_ff.win};
            else if (haddr == uvs_pkg::OFF_RESULT1)
                hrdata <= {8'h00, res_ff.ch1};
            else if (haddr == uvs_pkg::OFF_RESULT2)
                hrdata <= {8'h00, res_ff.ch2};
            else if (haddr == uvs_pkg::OFF_RESULT3)
                hrdata <= {8'h00, res_ff.ch3};
            else
                hrdata <= '0;
        end
    end

    // Always ready, always OKAY
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // =========================================
    // Checks
    chk_ready_conv: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ready_ff == (state_ff == ST_CONV))
        else $error("ready not matching conversion");
    chk_pwrup_first: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && state_ff != ST_CONV && nxt_state == ST_CONV && pd_bit && !sb_bit)
        |-> state_ff == ST_PWRUP)
        else $error("conversion started without power-up");
    chk_wake_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && state_ff == ST_PWRUP && nxt_state == ST_CONV) |-> !sb_bit)
        else $error("wake delay skipped");
    chk_oneshot_clr: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && regular_end && mode == uvs_pkg::MODE_ONESHOT) |=> !run_bit)
        else $error("run bit not cleared");
    chk_abort_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && !measuring) |=> state_ff == ST_IDLE)
        else $error("abort not honoured");
    chk_trig_ignore: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && trig_fall && (state_ff == ST_PAUSE || (state_ff == ST_PWRUP && tmr_ff != '0)))
        |=> !ready_ff)
        else $error("start accepted in busy phase");
    chk_cnt_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (clk_en && cnt_clear) |=> win_ff == '0)
        else $error("window count not cleared");
    chk_stby_pause: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_ff == ST_PAUSE && sb_bit && $past(clk_en)) |-> standby_ff)
        else $error("no standby in pause");
endmodule

/* File: verification/tb_uvs_sequencer.sv */
// Self-checking bench for the measurement sequencer
`timescale 1ns/1ns
module tb_uvs_sequencer;
    localparam int PW = 20;
    localparam int WK = uvs_pkg::WAKE_CYC;
    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } uvs_row_t;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        fire = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        trigger_input;
    logic [2:0]  pdm_in;
    logic        ready_ff;
    logic        power_down_ff;
    logic        standby_ff;
    logic [31:0] rd;
    int          err_total = 0;
    int          samples_checked = 0;
    int          d;
    int          w;
    uvs_row_t    rows [12] = '{
        '{1'b0, 8'h00, 32'h0, 32'h42}, '{1'b0, 8'h04, 32'h0, 32'h0},
        '{1'b0, 8'h08, 32'h0, 32'h619}, '{1'b1, 8'h24, 32'hffffffff, 32'h0},
        '{1'b0, 8'h24, 32'h0, 32'h0}, '{1'b1, 8'h00, 32'h02, 32'h0},
        '{1'b1, 8'h04, 32'h11, 32'h0}, '{1'b1, 8'h08, 32'h002, 32'h0},
        '{1'b0, 8'h08, 32'h0, 32'h002}, '{1'b1, 8'h00, 32'h03, 32'h0},
        '{1'b1, 8'h04, 32'h0, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h11}};

    // ==========================================
    // Clock, design and far side
    always #2 clk_sys = ~clk_sys;
    uvs_sequencer #(.PWRUP_CYCLES(PW), .N_CH(3)) uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .trigger_input(trigger_input),
        .pdm_in(pdm_in), .ready_ff(ready_ff), .power_down_ff(power_down_ff),
        .standby_ff(standby_ff));
    uvs_far_end far (
        .clk_sys(clk_sys), .reset_n(reset_n), .fire(fire),
        .trigger_input(trigger_input), .pdm_in(pdm_in));

    // ==========================================
    // Reporting and compares
    task automatic close_out();
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_span(input string nm, input int lo, input int hi, input logic [31:0] g);
        samples_checked++;
        if ($isunknown(g) || g < lo || g > hi)
        begin
            err_total++;
            $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    // ==========================================
    // Bus and handshake helpers
    task automatic edge_ok();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            err_total++;
            close_out();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        edge_ok();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        edge_ok();
        rd = hrdata;
    endtask
    task automatic wait_lvl(input logic lvl, input int lim, output int c);
        c = 0;
        while (ready_ff !== lvl && c < lim)
        begin
            @(posedge clk_sys);
            c++;
        end
        if (ready_ff !== lvl)
        begin
            err_total++;
            close_out();
        end
    endtask
    task automatic stay_low(input int n);
        int bad;
        bad = 0;
        repeat (n)
        begin
            @(posedge clk_sys);
            bad += (ready_ff !== 1'b0);
        end
        chk_val("ready idle", 32'h0, bad); // Stray starts
    endtask
    task automatic pulse();
        @(posedge clk_sys);
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk_sys);
        chk_val("pd in reset", 32'h1, power_down_ff);
        reset_n <= 1'b1;
        foreach (rows[i])
        begin
            bus(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr)
                chk_val("register", rows[i].e, rd);
        end
        chk_val("hresp", 32'h0, hresp); // Always OKAY
        // One-shot with power-down and standby
        bus(1'b1, 8'h00, 32'hc3);
        wait_lvl(1'b1, 5000, d);
        chk_span("start delay", PW + WK - 2, PW + WK + 6, d); // Both delays
        wait_lvl(1'b0, 5000, w);
        chk_span("conv width", 1023, 1025, w); // Fixed count
        repeat (3) @(posedge clk_sys);
        chk_val("power down", 32'h1, power_down_ff); // Back to saving
        bus(1'b0, 8'h00, 32'h0);
        chk_val("ctrl", 32'h43, rd); // Run bit cleared
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b0, 8'h14 + 8'(4 * i), 32'h0);
            chk_val("result", 32'd1024 >> i, rd); // Per channel
        end
        // Repeat mode with standby, then abort
        bus(1'b1, 8'h00, 32'h02);
        bus(1'b1, 8'h04, 32'h01);
        bus(1'b1, 8'h00, 32'h83);
        wait_lvl(1'b1, 5000, d);
        wait_lvl(1'b0, 5000, w);
        repeat (3) @(posedge clk_sys);
        chk_val("standby", 32'h1, standby_ff); // Pause in standby
        wait_lvl(1'b1, 5000, d);
        chk_span("restart", 16 + WK - 10, 16 + WK + 4, d); // Pause plus wake
        bus(1'b1, 8'h00, 32'h03);
        wait_lvl(1'b0, 4, w); // Prompt stop
        repeat (3) @(posedge clk_sys);
        chk_val("abort standby", 32'h1, standby_ff); // Saving at once
        bus(1'b0, 8'h14, 32'h0);
        chk_val("kept result", 32'd1024, rd); // Nothing stored
        // Trigger mode with power-down
        bus(1'b1, 8'h00, 32'h02);
        bus(1'b1, 8'h04, 32'h20);
        bus(1'b1, 8'h00, 32'hc3);
        stay_low(50);
        pulse();
        wait_lvl(1'b1, 5000, d);
        chk_span("trig start", PW, PW + 8, d); // Edge start
        repeat (100) @(posedge clk_sys);
        pulse();
        wait_lvl(1'b0, 5000, w);
        pulse(); // Edge inside pause
        stay_low(300);
        pulse();
        wait_lvl(1'b1, 200, d); // Later edge taken
        wait_lvl(1'b0, 5000, w);
        // Window mode, three stop edges, clock count on
        bus(1'b1, 8'h00, 32'h02);
        bus(1'b1, 8'h04, 32'h0332);
        bus(1'b1, 8'h08, 32'h0620); // Pause above default for reads
        bus(1'b1, 8'h00, 32'h83);
        pulse();
        wait_lvl(1'b1, 5000, d);
        repeat (3)
        begin
            repeat (97) @(posedge clk_sys);
            pulse();
        end
        wait_lvl(1'b0, 400, w);
        chk_span("window tail", 0, 9, w); // Third edge ends it
        pulse(); // Edge inside pause
        bus(1'b0, 8'h10, 32'h0);
        chk_span("window count", 292, 306, rd); // Clock count
        bus(1'b0, 8'h14, 32'h0);
        chk_span("window result", 292, 306, rd); // Counted over window
        stay_low(200); // Pause edge ignored
        close_out();
    end
endmodule

/* File: verification/uvs_far_end.sv */
// Far side model: trigger source and per-channel pulse streams
`timescale 1ns/1ns
module uvs_far_end (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        fire,
    output logic             trigger_input,
    output logic [2:0]       pdm_in
);
    logic [2:0] low_cnt_ff;
    logic [1:0] ph_ff;
    // ==========================================
    // Trigger source
    // Four low cycles per request, idle high; spacing is the bench's duty
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            low_cnt_ff <= 3'h0;
        else if (fire)
            low_cnt_ff <= 3'h4;
        else if (low_cnt_ff != 3'h0)
            low_cnt_ff <= low_cnt_ff - 3'h1;
    end
    assign trigger_input = (low_cnt_ff == 3'h0);
    // ==========================================
    // Pulse streams at full, half and quarter density
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            ph_ff <= 2'h0;
        else
            ph_ff <= ph_ff + 2'h1;
    end
    assign pdm_in = {ph_ff == 2'h0, ph_ff[0], 1'b1};
endmodule
